// ===== hw/bscs_defs.svh
// offsets, field positions and reset values of the boot/security block
// assumes: included by bare name from the block's design files and its bench
`ifndef BSCS_DEFS_SVH
`define BSCS_DEFS_SVH

// ----------------------------------------------------------------------
// register byte addresses on the software bus
// ----------------------------------------------------------------------
`define BSCS_ADDR_SEC       8'h00
`define BSCS_ADDR_STATUS    8'h04
`define BSCS_ADDR_CTRL      8'h08
`define BSCS_ADDR_PROGCTL   8'h0C
`define BSCS_ADDR_MFG_ID    8'h10
`define BSCS_ADDR_DEV_ID    8'h14
`define BSCS_ADDR_TABLE     8'h18

// ----------------------------------------------------------------------
// loader-space location of the security byte
// ----------------------------------------------------------------------
`define BSCS_SEC_LOADER_ADDR 16'hFFFF

// ----------------------------------------------------------------------
// security byte fields (zero means active)
// ----------------------------------------------------------------------
`define BSCS_SEC_LOCK       0
`define BSCS_SEC_TBL_INH    1
`define BSCS_SEC_ENCRYPT    2
`define BSCS_SEC_OSC_HALF   7
`define BSCS_SEC_ERASED     8'hFF

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define BSCS_CTRL_PROG_MODE 0
`define BSCS_CTRL_ERASE_ALL 1
`define BSCS_PROGCTL_REBOOT 7

// ----------------------------------------------------------------------
// identification values, arbitrary
// ----------------------------------------------------------------------
`define BSCS_MFG_ID_VAL     8'h5A
`define BSCS_DEV_ID_VAL     8'hA5

// ----------------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------------
`define BSCS_RESP_OKAY      2'h0
`define BSCS_RESP_SLVERR    2'h2

`endif

// ===== hw/bscs_pkg.sv
// types shared by the boot/security block
// assumes: compiled before every design module of the block
package bscs_pkg;

  // ----------------------------------------------------------------------
  // write- and read-side handshake states, gray along the usual path
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSCS_W_IDLE = 2'b00,
    BSCS_W_RESP = 2'b01
  } bscs_wstate_t;

  typedef enum logic [1:0] {
    BSCS_R_IDLE = 2'b00,
    BSCS_R_DATA = 2'b01
  } bscs_rstate_t;

endpackage : bscs_pkg

// ===== hw/bscs_boot_latch.sv
// boot selection latch: samples strap pins during reset, holds until next reset
// assumes: straps synchronous to ref_clk and stable while reset is high
`timescale 1ns/1ps
`include "bscs_defs.svh"

module bscs_boot_latch (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic boot_strap_a,
  input  wire logic boot_strap_b,
  input  wire logic boot_strap_c,
  output logic      forced_loader_boot
);

  typedef struct packed {
    logic sampled;
    logic forced;
  } bscs_latch_t;

  bscs_latch_t st_q;
  bscs_latch_t st_d;

  // ----------------------------------------------------------------------
  // sample once in the first reset cycle
  // ----------------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.sampled = reset;
    // an unknown flag at power-up misses the hold branch and samples
    if (reset && st_q.sampled) begin
      st_d.forced = st_q.forced;
    end else if (reset) begin
      st_d.forced = (!boot_strap_a && !boot_strap_b) || !boot_strap_c;
    end
  end

  // straps are data, not reset values, so they go through the clocked path
  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  assign forced_loader_boot = st_q.forced;

endmodule : bscs_boot_latch

// ===== hw/bscs_p0_encoder.sv
// port-0 output encoder, registered
// assumes: key is a fixed parameter; byte stream synchronous to ref_clk
`timescale 1ns/1ps

module bscs_p0_encoder #(
  parameter logic [7:0] KEY = 8'h3C
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);

  function automatic logic [7:0] bscs_scramble(input logic [7:0] d);
    bscs_scramble = {d[0], d[7:1]} ^ KEY;
  endfunction : bscs_scramble

  logic [7:0] dout_q;
  logic [7:0] dout_d;

  always_comb begin
    dout_d = enable ? bscs_scramble(din) : din;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout_q <= 8'h00;
    end else begin
      dout_q <= dout_d;
    end
  end

  assign dout = dout_q;

endmodule : bscs_p0_encoder

// ===== hw/bscs_top.sv
// boot selection and code security block with an AXI4-Lite register slave
// assumes: single clock, synchronous active-high reset, AXI4-Lite master
`timescale 1ns/1ps
`include "bscs_defs.svh"

// Notes on behaviour
// - without a forced loader boot, execution starts from the application flash.
// - straps a and b both low, or strap c low, at reset select the loader flash.
// - setting registers cannot be reached while flash programming mode is on.
// - a security bit once cleared stays cleared until an erase-all or a reset.
// - manufacturer and device identity values are fixed and read only.
// - the security byte sits at the top address of the loader flash space.
// - with the lock bit zero, outside access to flash and settings is refused.
// - inhibit zero makes external-code table reads return external data only.
// - table reads from internal code may always reach both memories.
// - inhibit one puts no region limit on table reads.
// - with encryption on, port-0 data passes through the encoder.
// - encryption once on stays on until a whole-chip erase or a reset.
// - security bit 7 at zero halves the oscillator amplifier gain.
// - the soft-reboot bit reads one while running in forced loader boot.
module bscs_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        boot_strap_a,
  input  wire logic        boot_strap_b,
  input  wire logic        boot_strap_c,
  input  wire logic        tbl_fetch_external,
  input  wire logic        tbl_target_internal,
  input  wire logic        ext_flash_req,
  input  wire logic [15:0] ext_flash_addr,
  input  wire logic        ext_flash_loader,
  input  wire logic [7:0]  p0_data_in,
  output logic [7:0]       p0_data_out,
  output logic             boot_from_loader,
  output logic             tbl_internal_grant,
  output logic             ext_flash_grant,
  output logic             ext_sec_hit,
  output logic             osc_gain_half,
  output logic             encrypt_active,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    bscs_pkg::bscs_wstate_t ws;
    bscs_pkg::bscs_rstate_t rs;
    logic                   aw_have;
    logic                   w_have;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic                   wlane0;
    logic [1:0]             bresp;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [7:0]             sec;
    logic                   prog_mode;
    logic                   boot_ldr;
    logic                   tbl_grant;
    logic                   ext_grant;
    logic                   sec_hit;
    logic                   osc_half;
    logic                   enc_on;
  } bscs_state_t;

  bscs_state_t st_q;
  bscs_state_t st_d;
  logic        forced_loader_boot;

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  bscs_boot_latch u_boot (
    .ref_clk            (ref_clk),
    .reset              (reset),
    .boot_strap_a       (boot_strap_a),
    .boot_strap_b       (boot_strap_b),
    .boot_strap_c       (boot_strap_c),
    .forced_loader_boot (forced_loader_boot)
  );

  bscs_p0_encoder u_enc (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (st_q.enc_on),
    .din     (p0_data_in),
    .dout    (p0_data_out)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic bscs_settings_open(input bscs_state_t s);
    // locked or programming mode both close the setting registers
    bscs_settings_open = !s.prog_mode && s.sec[`BSCS_SEC_LOCK];
  endfunction : bscs_settings_open

  function automatic logic [31:0] bscs_read(input bscs_state_t s, input logic [7:0] a);
    bscs_read = 32'h0000_0000;
    unique case (a)
      `BSCS_ADDR_SEC:     bscs_read = {24'h00_0000, s.sec};
      `BSCS_ADDR_STATUS:  bscs_read = {26'h000_0000, s.enc_on, s.osc_half,
                                       !s.sec[`BSCS_SEC_LOCK], s.boot_ldr};
      `BSCS_ADDR_CTRL:    bscs_read = {31'h0000_0000, s.prog_mode};
      `BSCS_ADDR_PROGCTL: bscs_read = {24'h00_0000, s.boot_ldr, 7'h00};
      `BSCS_ADDR_MFG_ID:  bscs_read = {24'h00_0000, `BSCS_MFG_ID_VAL};
      `BSCS_ADDR_DEV_ID:  bscs_read = {24'h00_0000, `BSCS_DEV_ID_VAL};
      default:            bscs_read = 32'h0000_0000;
    endcase
  endfunction : bscs_read

  function automatic logic bscs_mapped(input logic [7:0] a);
    bscs_mapped = (a == `BSCS_ADDR_SEC) || (a == `BSCS_ADDR_STATUS) ||
                  (a == `BSCS_ADDR_CTRL) || (a == `BSCS_ADDR_PROGCTL) ||
                  (a == `BSCS_ADDR_MFG_ID) || (a == `BSCS_ADDR_DEV_ID);
  endfunction : bscs_mapped

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.boot_ldr = forced_loader_boot;
    // write address and data may arrive in either order
    if (s_axi_awvalid && !st_q.aw_have && st_q.ws == bscs_pkg::BSCS_W_IDLE) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !st_q.w_have && st_q.ws == bscs_pkg::BSCS_W_IDLE) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wlane0 = s_axi_wstrb[0];
    end
    unique case (st_q.ws)
      bscs_pkg::BSCS_W_IDLE: begin
        if (st_q.aw_have && st_q.w_have) begin
          st_d.aw_have = 1'b0;
          st_d.w_have  = 1'b0;
          st_d.ws      = bscs_pkg::BSCS_W_RESP;
          st_d.bresp   = `BSCS_RESP_OKAY;
          if (!bscs_mapped(st_q.awaddr)) begin
            st_d.bresp = `BSCS_RESP_SLVERR;
          end else if (st_q.awaddr == `BSCS_ADDR_CTRL) begin
            if (st_q.wlane0) begin
              st_d.prog_mode = st_q.wdata[`BSCS_CTRL_PROG_MODE];
              if (st_q.wdata[`BSCS_CTRL_ERASE_ALL] && !st_q.wdata[`BSCS_CTRL_PROG_MODE]) begin
                st_d.sec = `BSCS_SEC_ERASED;
              end
            end
          end else if (st_q.awaddr == `BSCS_ADDR_SEC && bscs_settings_open(st_q)) begin
            // only one-to-zero moves are possible
            if (st_q.wlane0) begin
              st_d.sec = st_q.sec & st_q.wdata[7:0];
            end
          end else begin
            // ids, status, locked or programming-mode settings: refused
            st_d.bresp = `BSCS_RESP_SLVERR;
          end
        end
      end
      bscs_pkg::BSCS_W_RESP: begin
        if (s_axi_bready) begin
          st_d.ws = bscs_pkg::BSCS_W_IDLE;
        end
      end
      default: st_d.ws = bscs_pkg::BSCS_W_IDLE;
    endcase
    unique case (st_q.rs)
      bscs_pkg::BSCS_R_IDLE: begin
        if (s_axi_arvalid) begin
          st_d.rs    = bscs_pkg::BSCS_R_DATA;
          st_d.rdata = bscs_read(st_q, {s_axi_araddr[7:2], 2'b00});
          st_d.rresp = `BSCS_RESP_OKAY;
          if (!bscs_mapped({s_axi_araddr[7:2], 2'b00})) begin
            st_d.rresp = `BSCS_RESP_SLVERR;
          end else if ({s_axi_araddr[7:2], 2'b00} == `BSCS_ADDR_SEC ||
                       {s_axi_araddr[7:2], 2'b00} == `BSCS_ADDR_MFG_ID ||
                       {s_axi_araddr[7:2], 2'b00} == `BSCS_ADDR_DEV_ID) begin
            if (!bscs_settings_open(st_q)) begin
              st_d.rdata = 32'h0000_0000;
              st_d.rresp = `BSCS_RESP_SLVERR;
            end
          end
        end
      end
      bscs_pkg::BSCS_R_DATA: begin
        if (s_axi_rready) begin
          st_d.rs = bscs_pkg::BSCS_R_IDLE;
        end
      end
      default: st_d.rs = bscs_pkg::BSCS_R_IDLE;
    endcase
    // table-read region gate
    st_d.tbl_grant = !tbl_target_internal || !tbl_fetch_external ||
                     st_d.sec[`BSCS_SEC_TBL_INH];
    // outside programmer access to flash contents
    st_d.ext_grant = ext_flash_req && st_d.sec[`BSCS_SEC_LOCK];
    st_d.sec_hit   = ext_flash_req && ext_flash_loader &&
                     ext_flash_addr == `BSCS_SEC_LOADER_ADDR && !st_d.prog_mode &&
                     st_d.sec[`BSCS_SEC_LOCK];
    st_d.osc_half  = !st_d.sec[`BSCS_SEC_OSC_HALF];
    st_d.enc_on    = !st_d.sec[`BSCS_SEC_ENCRYPT];
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // security byte has no documented reset; erased value used at reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q          <= '0;
      st_q.ws       <= bscs_pkg::BSCS_W_IDLE;
      st_q.rs       <= bscs_pkg::BSCS_R_IDLE;
      st_q.sec      <= `BSCS_SEC_ERASED;
    end else begin
      st_q <= st_d;
    end
  end

  assign boot_from_loader   = st_q.boot_ldr;
  assign tbl_internal_grant = st_q.tbl_grant;
  assign ext_flash_grant    = st_q.ext_grant;
  assign ext_sec_hit        = st_q.sec_hit;
  assign osc_gain_half      = st_q.osc_half;
  assign encrypt_active     = st_q.enc_on;
  assign s_axi_awready      = st_q.ws == bscs_pkg::BSCS_W_IDLE && !st_q.aw_have;
  assign s_axi_wready       = st_q.ws == bscs_pkg::BSCS_W_IDLE && !st_q.w_have;
  assign s_axi_bvalid       = st_q.ws == bscs_pkg::BSCS_W_RESP;
  assign s_axi_bresp        = st_q.bresp;
  assign s_axi_arready      = st_q.rs == bscs_pkg::BSCS_R_IDLE;
  assign s_axi_rvalid       = st_q.rs == bscs_pkg::BSCS_R_DATA;
  assign s_axi_rdata        = st_q.rdata;
  assign s_axi_rresp        = st_q.rresp;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_boot_app;
    @(posedge ref_clk) disable iff (reset)
      !forced_loader_boot |=> !boot_from_loader;
  endproperty
  a_boot_app: assert property (p_boot_app) else $error("boot source not application");

  property p_reboot_bit;
    @(posedge ref_clk) disable iff (reset)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `BSCS_ADDR_PROGCTL && boot_from_loader
       && forced_loader_boot) |=> s_axi_rvalid && s_axi_rdata[`BSCS_PROGCTL_REBOOT];
  endproperty
  a_reboot_bit: assert property (p_reboot_bit) else $error("reboot bit not one");

  property p_sticky;
    @(posedge ref_clk) disable iff (reset)
      (!st_q.sec[`BSCS_SEC_LOCK] && !(st_q.ws == bscs_pkg::BSCS_W_IDLE && st_q.aw_have &&
       st_q.w_have && st_q.awaddr == `BSCS_ADDR_CTRL)) |=> !st_q.sec[`BSCS_SEC_LOCK];
  endproperty
  a_sticky: assert property (p_sticky) else $error("security bit returned to one");

  property p_lock_ext;
    @(posedge ref_clk) disable iff (reset)
      (!st_q.sec[`BSCS_SEC_LOCK] ##1 !st_q.sec[`BSCS_SEC_LOCK]) |-> !ext_flash_grant;
  endproperty
  a_lock_ext: assert property (p_lock_ext) else $error("locked flash access granted");

  property p_tbl;
    @(posedge ref_clk) disable iff (reset)
      (tbl_fetch_external && tbl_target_internal && !st_q.sec[`BSCS_SEC_TBL_INH] &&
       !$changed(st_q.sec)) |=> !tbl_internal_grant;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read reached internal flash");

  property p_tbl_int;
    @(posedge ref_clk) disable iff (reset)
      !reset && !tbl_fetch_external |=> tbl_internal_grant;
  endproperty
  a_tbl_int: assert property (p_tbl_int) else $error("internal table read refused");

  property p_osc;
    @(posedge ref_clk) disable iff (reset)
      $fell(st_q.sec[`BSCS_SEC_OSC_HALF]) |=> osc_gain_half [*2];
  endproperty
  a_osc: assert property (p_osc) else $error("gain not halved");

  property p_prog_block;
    @(posedge ref_clk) disable iff (reset)
      (s_axi_arvalid && s_axi_arready && st_q.prog_mode &&
       s_axi_araddr == `BSCS_ADDR_MFG_ID) |=> s_axi_rvalid && s_axi_rresp == `BSCS_RESP_SLVERR;
  endproperty
  a_prog_block: assert property (p_prog_block) else $error("id read in programming mode");

endmodule : bscs_top

// ===== verification/bscs_far_side.sv
// far-side model: reset-time strap switches and an external flash programmer
// assumes: commanded by the bench from ref_clk rising edges by non-blocking assignment
`timescale 1ns/1ps

module bscs_far_side (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [2:0]  strap_cfg,
  input  wire logic        cmd_req,
  input  wire logic [15:0] cmd_addr,
  input  wire logic        cmd_loader,
  output logic             boot_strap_a,
  output logic             boot_strap_b,
  output logic             boot_strap_c,
  output logic             ext_flash_req,
  output logic [15:0]      ext_flash_addr,
  output logic             ext_flash_loader
);
  // ----------------------------------------------------------------
  // strap switches
  // ----------------------------------------------------------------
  // pressed levels stand through all of reset; released pins pull high
  always_comb begin
    {boot_strap_a, boot_strap_b, boot_strap_c} = reset ? strap_cfg : 3'b111;
  end

  // ----------------------------------------------------------------
  // programmer
  // ----------------------------------------------------------------
  // idle lines show the inverse of the last value, so a stale match is caught
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_flash_req    <= 1'b0;
      ext_flash_addr   <= 16'h0000;
      ext_flash_loader <= 1'b0;
    end else if (cmd_req) begin
      ext_flash_req    <= 1'b1;
      ext_flash_addr   <= cmd_addr;
      ext_flash_loader <= cmd_loader;
    end else if (ext_flash_req) begin
      ext_flash_req    <= 1'b0;
      ext_flash_addr   <= ~ext_flash_addr;
      ext_flash_loader <= ~ext_flash_loader;
    end
  end
endmodule : bscs_far_side

// ===== verification/tb_bscs_top.sv
// self-checking bench of the boot selection and code security block
// assumes: design and far-side model compiled first; bready and rready held high
`timescale 1ns/1ps
`include "bscs_defs.svh"

module tb_bscs_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] straps;
    logic       fe;
    logic       ti;
    logic       boot;
    logic       grant;
  } bscs_row_t;

  localparam logic [1:0] OK = `BSCS_RESP_OKAY;
  localparam logic [1:0] ER = `BSCS_RESP_SLVERR;

  logic        ref_clk, reset, boot_strap_a, boot_strap_b, boot_strap_c;
  logic        tbl_fetch_external, tbl_target_internal, ext_flash_req, ext_flash_loader;
  logic        cmd_req, cmd_loader, boot_from_loader, tbl_internal_grant, ext_flash_grant;
  logic        ext_sec_hit, osc_gain_half, encrypt_active;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  strap_cfg;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  p0_data_in, p0_data_out, s_axi_awaddr, s_axi_araddr;
  logic [15:0] ext_flash_addr, cmd_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          mismatches, cmp_count;
  bscs_row_t   rows [6];

  bscs_far_side far (
    .ref_clk(ref_clk), .reset(reset), .strap_cfg(strap_cfg), .cmd_req(cmd_req),
    .cmd_addr(cmd_addr), .cmd_loader(cmd_loader), .boot_strap_a(boot_strap_a),
    .boot_strap_b(boot_strap_b), .boot_strap_c(boot_strap_c),
    .ext_flash_req(ext_flash_req), .ext_flash_addr(ext_flash_addr),
    .ext_flash_loader(ext_flash_loader)
  );

  bscs_top dut (
    .ref_clk(ref_clk), .reset(reset), .boot_strap_a(boot_strap_a),
    .boot_strap_b(boot_strap_b), .boot_strap_c(boot_strap_c),
    .tbl_fetch_external(tbl_fetch_external), .tbl_target_internal(tbl_target_internal),
    .ext_flash_req(ext_flash_req), .ext_flash_addr(ext_flash_addr),
    .ext_flash_loader(ext_flash_loader), .p0_data_in(p0_data_in),
    .p0_data_out(p0_data_out), .boot_from_loader(boot_from_loader),
    .tbl_internal_grant(tbl_internal_grant), .ext_flash_grant(ext_flash_grant),
    .ext_sec_hit(ext_sec_hit), .osc_gain_half(osc_gain_half),
    .encrypt_active(encrypt_active), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] enc(input logic [7:0] d);
    return {d[0], d[7:1]} ^ 8'h3C;
  endfunction : enc

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // waits bounded; a hung handshake ends the run
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) begin
      mismatches++;
      conclude();
    end
    chk($sformatf("bresp@%h", a), 32'(er), 32'(s_axi_bresp));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                     input bit cd);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 64) begin
      mismatches++;
      conclude();
    end
    chk($sformatf("rresp@%h", a), 32'(er), 32'(s_axi_rresp));
    if (cd) chk($sformatf("rdata@%h", a), e, s_axi_rdata);
  endtask : axr

  task automatic drv(input logic fe, ti, input logic [7:0] p, input logic rq, ld,
                     input logic [15:0] ad);
    tbl_fetch_external  <= fe;
    tbl_target_internal <= ti;
    p0_data_in          <= p;
    cmd_req             <= rq;
    cmd_loader          <= ld;
    cmd_addr            <= ad;
    cyc(4);
  endtask : drv

  task automatic rst(input logic [2:0] s);
    strap_cfg <= s;
    reset     <= 1'b1;
    cyc(2);
    reset     <= 1'b0;
    cyc(2);
  endtask : rst

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    cmp_count  = 0;
    reset      = 1'b1;
    strap_cfg  = 3'b111;
    {cmd_req, cmd_loader, cmd_addr, tbl_fetch_external, tbl_target_internal} = '0;
    {p0_data_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_wstrb  = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    // straps {a,b,c}, table fetch external, target internal, boot, grant
    rows[0] = '{3'b111, 1'b0, 1'b1, 1'b0, 1'b1};
    rows[1] = '{3'b001, 1'b1, 1'b1, 1'b1, 1'b1};
    rows[2] = '{3'b011, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[3] = '{3'b101, 1'b0, 1'b1, 1'b0, 1'b1};
    rows[4] = '{3'b110, 1'b1, 1'b1, 1'b1, 1'b1};
    rows[5] = '{3'b000, 1'b0, 1'b0, 1'b1, 1'b1};
    cyc(2);
    // straps read high after reset: the latched choice must hold
    foreach (rows[i]) begin
      rst(rows[i].straps);
      drv(rows[i].fe, rows[i].ti, 8'h00, 1'b0, 1'b0, 16'h0000);
      chk("boot_from_loader", 32'(rows[i].boot), 32'(boot_from_loader));
      chk("tbl_internal_grant", 32'(rows[i].grant), 32'(tbl_internal_grant));
      axr(`BSCS_ADDR_PROGCTL, {24'h0, rows[i].boot, 7'h00}, OK, 1'b1);
      axr(`BSCS_ADDR_STATUS, {31'h0, rows[i].boot}, OK, 1'b1);
    end
    rst(3'b111);
    axr(`BSCS_ADDR_MFG_ID, {24'h0, `BSCS_MFG_ID_VAL}, OK, 1'b1);
    axw(`BSCS_ADDR_DEV_ID, 32'h0, ER);
    axr(`BSCS_ADDR_DEV_ID, {24'h0, `BSCS_DEV_ID_VAL}, OK, 1'b1);
    axw(8'hFC, 32'hFF, ER);
    axr(8'hFC, 32'h0, ER, 1'b0);
    drv(1'b0, 1'b1, 8'h81, 1'b1, 1'b1, `BSCS_SEC_LOADER_ADDR);
    chk("ext_sec_hit", 32'h1, 32'(ext_sec_hit));
    chk("ext_flash_grant", 32'h1, 32'(ext_flash_grant));
    chk("p0_data_out", 32'h81, 32'(p0_data_out));
    drv(1'b0, 1'b1, 8'h81, 1'b1, 1'b1, 16'hFFFE);
    chk("ext_sec_hit", 32'h0, 32'(ext_sec_hit));
    drv(1'b1, 1'b1, 8'h81, 1'b1, 1'b0, 16'hFFFF);
    chk("ext_sec_hit", 32'h0, 32'(ext_sec_hit));
    axw(`BSCS_ADDR_SEC, 32'hFD, OK);
    drv(1'b1, 1'b1, 8'h81, 1'b1, 1'b1, 16'hFFFF);
    chk("tbl_internal_grant", 32'h0, 32'(tbl_internal_grant));
    drv(1'b0, 1'b1, 8'h81, 1'b1, 1'b1, 16'hFFFF);
    chk("tbl_internal_grant", 32'h1, 32'(tbl_internal_grant));
    axw(`BSCS_ADDR_SEC, 32'h7B, OK);
    chk("osc_gain_half", 32'h1, 32'(osc_gain_half));
    chk("encrypt_active", 32'h1, 32'(encrypt_active));
    axr(`BSCS_ADDR_STATUS, 32'hC, OK, 1'b1);
    for (int k = 0; k < 4; k++) begin
      drv(1'b0, 1'b1, 8'(k * 71 + 1), 1'b1, 1'b1, 16'hFFFF);
      chk("p0_data_out", 32'(enc(8'(k * 71 + 1))), 32'(p0_data_out));
    end
    // cleared bits cannot be written back to one
    axw(`BSCS_ADDR_SEC, 32'hFF, OK);
    axr(`BSCS_ADDR_SEC, 32'h79, OK, 1'b1);
    chk("encrypt_active", 32'h1, 32'(encrypt_active));
    axw(`BSCS_ADDR_CTRL, 32'h1, OK);
    axr(`BSCS_ADDR_SEC, 32'h0, ER, 1'b1);
    axr(`BSCS_ADDR_MFG_ID, 32'h0, ER, 1'b1);
    axw(`BSCS_ADDR_SEC, 32'h0, ER);
    axw(`BSCS_ADDR_CTRL, 32'h0, OK);
    axr(`BSCS_ADDR_SEC, 32'h79, OK, 1'b1);
    // lock goes last, after everything else is set and read back
    axw(`BSCS_ADDR_SEC, 32'hFE, OK);
    drv(1'b0, 1'b1, 8'h81, 1'b1, 1'b1, 16'hFFFF);
    chk("ext_flash_grant", 32'h0, 32'(ext_flash_grant));
    chk("ext_sec_hit", 32'h0, 32'(ext_sec_hit));
    axr(`BSCS_ADDR_SEC, 32'h0, ER, 1'b1);
    axr(`BSCS_ADDR_DEV_ID, 32'h0, ER, 1'b1);
    axw(`BSCS_ADDR_SEC, 32'hFF, ER);
    axr(`BSCS_ADDR_STATUS, 32'hE, OK, 1'b1);
    axw(`BSCS_ADDR_CTRL, 32'h2, OK);
    axr(`BSCS_ADDR_SEC, {24'h0, `BSCS_SEC_ERASED}, OK, 1'b1);
    drv(1'b1, 1'b1, 8'h81, 1'b1, 1'b1, 16'hFFFF);
    chk("encrypt_active", 32'h0, 32'(encrypt_active));
    chk("osc_gain_half", 32'h0, 32'(osc_gain_half));
    chk("ext_flash_grant", 32'h1, 32'(ext_flash_grant));
    chk("tbl_internal_grant", 32'h1, 32'(tbl_internal_grant));
    chk("p0_data_out", 32'h81, 32'(p0_data_out));
    conclude();
  end
endmodule : tb_bscs_top
